//--- rtl/programmable_io_ports.sv
/*
  programmable port bank: 63 bidirectional pins and one input-only pin in
  eight groups, registers reached over APB. assumes the pads resolve the pin
  level from PIN_O, PIN_OE_O and PIN_PULLUP_O, and that the peripherals share
  the bank clock.
*/
// Design decisions made here: the APB slave port and the register addresses.
// Function
// - 63 bidirectional pins, shared with peripherals
// - one direction bit per pin
// - input-only pin: no pull-up, no driver
// - input-only pin has no direction bit
// - one pull-up enable per four pins
// - pull-up only while pin is input
// - peripheral output overrides direction bit
// - write stores latch, read senses pin
// - group 2 pins get LED sink drive
// - five timer outputs get high drive
module programmable_io_ports
  import gpio_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [NUM_PINS-1:0] PIN_I,
  output logic [NUM_PINS-1:0] PIN_O,
  output logic [NUM_PINS-1:0] PIN_OE_O,
  output logic [NUM_PINS-1:0] PIN_PULLUP_O,
  input wire logic [NUM_PINS-1:0] PERIPH_OE_I,
  input wire logic [NUM_PINS-1:0] PERIPH_DO_I,
  output logic [NUM_PINS-1:0] PERIPH_DI_O,
  output logic [GROUP_W-1:0] LED_SINK_O,
  output logic [TIMER_OUTS-1:0] TIMER_DRIVE_O
);
  logic [7:0] latch_r [NUM_GROUPS];  // output latches
  logic [7:0] dir_r [NUM_GROUPS];    // direction bits, 1 = output
  logic [PU_BITS-1:0] pu_r;          // pull-up block enables
  logic [NUM_PINS-1:0] dir_flat;     // direction bits as one vector
  logic [NUM_PINS-1:0] sense_flat;   // synchronised pins as one vector
  logic [2:0] rgn;                   // address region
  logic [2:0] grp;                   // group index within region
  logic access;                      // access phase, answer not yet given
  logic wr_done;                     // write takes effect this edge
  logic hit;                         // address is mapped
  logic [31:0] rd_nxt;               // read data for the pending access

  assign rgn = PADDR_I[RGN_LSB +: 3];
  assign grp = PADDR_I[GRP_LSB +: 3];
  assign access = PSEL_I & PENABLE_I & ~PREADY_O;
  assign wr_done = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;

  // address decode, byte lanes [1:0] ignored in the data and direction regions only
  always_comb begin
    hit = 1'b0;
    rd_nxt = RD_ZERO;
    case (rgn)
      RGN_DATA: begin
        hit = 1'b1;
        rd_nxt[7:0] = sense_flat[grp*GROUP_W +: GROUP_W];
      end
      RGN_DIR: begin
        hit = 1'b1;
        rd_nxt[7:0] = dir_r[grp];
      end
      default: begin
        if (PADDR_I == OFS_PULLUP) begin
          hit = 1'b1;
          rd_nxt[PU_BITS-1:0] = pu_r;
        end else if (PADDR_I == OFS_LED) begin
          hit = 1'b1;
          rd_nxt[GROUP_W-1:0] = LED_SINK_O;
        end else if (PADDR_I == OFS_TIMER) begin
          hit = 1'b1;
          rd_nxt[TIMER_OUTS-1:0] = TIMER_DRIVE_O;
        end
      end
    endcase
  end

  // one wait state: answer registered in the cycle after the access begins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= RD_ZERO;
    end else begin
      PREADY_O <= access;
      PSLVERR_O <= access & ~hit;
      // unmapped reads give zero along with the error
      if (access) begin
        PRDATA_O <= PWRITE_I ? RD_ZERO : rd_nxt;
      end
    end
  end

  // output latches and direction bits, per group
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < NUM_GROUPS; i++) begin
        latch_r[i] <= RST_BYTE;
        dir_r[i] <= RST_BYTE;
      end
    end else if (wr_done) begin
      if (rgn == RGN_DATA) begin
        latch_r[grp] <= PWDATA_I[7:0];
      end
      if (rgn == RGN_DIR) begin
        dir_r[grp] <= (grp == 3'(IN_ONLY_GROUP)) ? (PWDATA_I[7:0] & ~IN_ONLY_MASK6) : PWDATA_I[7:0];
      end
    end
  end

  // pull-up enables and drive strength controls
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pu_r <= RST_PULLUP;
      LED_SINK_O <= RST_BYTE;
      TIMER_DRIVE_O <= RST_TIMER;
    end else if (wr_done) begin
      if (PADDR_I == OFS_PULLUP) begin
        pu_r <= PWDATA_I[PU_BITS-1:0];
      end
      if (PADDR_I == OFS_LED) begin
        LED_SINK_O <= PWDATA_I[GROUP_W-1:0];
      end
      if (PADDR_I == OFS_TIMER) begin
        TIMER_DRIVE_O <= PWDATA_I[TIMER_OUTS-1:0];
      end
    end
  end

  // eight groups share pins with peripherals
  group_if gif[NUM_GROUPS] ();
  for (genvar i = 0; i < NUM_GROUPS; i++) begin : g_grp
    assign gif[i].dir = dir_r[i];
    assign gif[i].latch = latch_r[i];
    assign gif[i].pu_en = pu_r[i*PU_PER_GROUP +: PU_PER_GROUP];
    assign gif[i].p_oe = PERIPH_OE_I[i*GROUP_W +: GROUP_W];
    assign gif[i].p_do = PERIPH_DO_I[i*GROUP_W +: GROUP_W];
    assign sense_flat[i*GROUP_W +: GROUP_W] = gif[i].sense;
    assign dir_flat[i*GROUP_W +: GROUP_W] = dir_r[i];
    pin_group #(
      .IN_ONLY((i == IN_ONLY_GROUP) ? IN_ONLY_MASK6 : RST_BYTE)
    ) u_grp (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .g(gif[i]),
      .pin_i(PIN_I[i*GROUP_W +: GROUP_W]),
      .pin_o(PIN_O[i*GROUP_W +: GROUP_W]),
      .oe_o(PIN_OE_O[i*GROUP_W +: GROUP_W]),
      .pu_o(PIN_PULLUP_O[i*GROUP_W +: GROUP_W])
    );
  end

  // peripherals read the same sensed level; input mode is software's job
  assign PERIPH_DI_O = sense_flat;

  // checks

  // input-only pin never drives and never pulls up
  property p_in_only;
    @(posedge CLK_I) disable iff (RST_I)
    !PIN_OE_O[IN_ONLY_PIN] && !PIN_PULLUP_O[IN_ONLY_PIN];
  endproperty
  a_in_only: assert property (p_in_only) else $error("input-only pin driven or pulled");

  // direction bit of input-only pin stays clear
  property p_no_dir;
    @(posedge CLK_I) disable iff (RST_I)
    wr_done && rgn == RGN_DIR && grp == 3'(IN_ONLY_GROUP) |=> !dir_flat[IN_ONLY_PIN];
  endproperty
  a_no_dir: assert property (p_no_dir) else $error("input-only pin got a direction bit");

  // pull-up never on a driven pin
  property p_pu_input;
    @(posedge CLK_I) disable iff (RST_I)
    (PIN_PULLUP_O & PIN_OE_O) == '0;
  endproperty
  a_pu_input: assert property (p_pu_input) else $error("pull-up on output pin");

  // first block pull-up follows its enable
  property p_pu_block;
    @(posedge CLK_I) disable iff (RST_I)
    |PIN_PULLUP_O[PU_BLOCK-1:0] |-> $past(pu_r[0]);
  endproperty
  a_pu_block: assert property (p_pu_block) else $error("pull-up without block enable");

  // group 0 driver enable is direction or peripheral claim, one cycle late
  property p_oe;
    @(posedge CLK_I) disable iff (RST_I)
    !$past(RST_I) |-> PIN_OE_O[7:0] == ($past(dir_flat[7:0]) | $past(PERIPH_OE_I[7:0]));
  endproperty
  a_oe: assert property (p_oe) else $error("group 0 driver enable wrong");

  // latch write reaches pin two edges later when no peripheral claims it
  property p_latch_out;
    @(posedge CLK_I) disable iff (RST_I)
    wr_done && rgn == RGN_DATA && grp == 3'h0 && PERIPH_OE_I[7:0] == '0 ##1 PERIPH_OE_I[7:0] == '0
    |=> PIN_O[7:0] == $past(PWDATA_I[7:0], 2);
  endproperty
  a_latch_out: assert property (p_latch_out) else $error("latch not on pin");

  // a read of a steady pin group returns its level
  property p_read_pin;
    @(posedge CLK_I) disable iff (RST_I)
    access && !PWRITE_I && rgn == RGN_DATA && $stable(PIN_I) && $past(PIN_I, 2) == PIN_I
    && $past(PIN_I, 3) == PIN_I |=> PRDATA_O[7:0] == $past(PIN_I[grp*GROUP_W +: GROUP_W]);
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("read data is not pin level");

  // LED and timer drive follow their writes
  property p_led;
    @(posedge CLK_I) disable iff (RST_I)
    wr_done && PADDR_I == OFS_LED |=> LED_SINK_O == $past(PWDATA_I[7:0]);
  endproperty
  a_led: assert property (p_led) else $error("LED sink not written");

  property p_timer;
    @(posedge CLK_I) disable iff (RST_I)
    wr_done && PADDR_I == OFS_TIMER |=> TIMER_DRIVE_O == $past(PWDATA_I[4:0]);
  endproperty
  a_timer: assert property (p_timer) else $error("timer drive not written");

  // after reset every pin is an undriven input without pull-up
  property p_reset;
    @(posedge CLK_I)
    $fell(RST_I) |-> PIN_OE_O == '0 && PIN_PULLUP_O == '0 && LED_SINK_O == '0 && TIMER_DRIVE_O == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("controls not cleared by reset");

  // every access is answered after exactly one wait cycle
  property p_ready;
    @(posedge CLK_I) disable iff (RST_I)
    access |=> PREADY_O ##1 !PREADY_O;
  endproperty
  a_ready: assert property (p_ready) else $error("answer timing wrong");

  // unmapped access answers with an error and zero data
  property p_err_unmapped;
    @(posedge CLK_I) disable iff (RST_I)
    access && !hit |=> PSLVERR_O && PRDATA_O == RD_ZERO;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

  // a direction write to group 0 lands bit for bit
  property p_dir_write;
    @(posedge CLK_I) disable iff (RST_I)
    wr_done && rgn == RGN_DIR && grp == 3'h0 |=> dir_flat[7:0] == $past(PWDATA_I[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  // a claimed pin shows the peripheral level, not the latch
  property p_periph_out;
    @(posedge CLK_I) disable iff (RST_I)
    !$past(RST_I) && $past(PERIPH_OE_I[0]) |-> PIN_O[0] == $past(PERIPH_DO_I[0]);
  endproperty
  a_periph_out: assert property (p_periph_out) else $error("peripheral level not on pin");

  // pull-up drops on a pin that a peripheral drives
  property p_pu_periph;
    @(posedge CLK_I) disable iff (RST_I)
    (PIN_PULLUP_O & $past(PERIPH_OE_I)) == '0;
  endproperty
  a_pu_periph: assert property (p_pu_periph) else $error("pull-up on peripheral output");

  // peripherals see the pad level two edges late, never the first flop
  property p_sense_sync;
    @(posedge CLK_I) disable iff (RST_I)
    !$past(RST_I) && !$past(RST_I, 2) |-> PERIPH_DI_O == $past(PIN_I, 2);
  endproperty
  a_sense_sync: assert property (p_sense_sync) else $error("sensed level not two flops late");

  // LED sink drive changes only through its register
  property p_led_hold;
    @(posedge CLK_I) disable iff (RST_I)
    !(wr_done && PADDR_I == OFS_LED) |=> $stable(LED_SINK_O);
  endproperty
  a_led_hold: assert property (p_led_hold) else $error("LED sink changed without write");

  // timer drive changes only through its register
  property p_timer_hold;
    @(posedge CLK_I) disable iff (RST_I)
    !(wr_done && PADDR_I == OFS_TIMER) |=> $stable(TIMER_DRIVE_O);
  endproperty
  a_timer_hold: assert property (p_timer_hold) else $error("timer drive changed without write");

  c_periph: cover property (@(posedge CLK_I) disable iff (RST_I) PERIPH_OE_I[0] && !dir_flat[0] ##1 PIN_OE_O[0]);
  c_pullup: cover property (@(posedge CLK_I) disable iff (RST_I) |PIN_PULLUP_O);
  c_err: cover property (@(posedge CLK_I) disable iff (RST_I) PREADY_O && PSLVERR_O);
  c_led: cover property (@(posedge CLK_I) disable iff (RST_I) wr_done && PADDR_I == OFS_LED);
  c_in_only: cover property (@(posedge CLK_I) disable iff (RST_I) access && rgn == RGN_DATA && grp == 3'h6);
endmodule : programmable_io_ports

//--- rtl/gpio_pkg.sv
/*
  constants shared by the programmable port bank: geometry, register map,
  reset values. assumes an 8-bit APB byte address with word-aligned registers.
*/
package gpio_pkg;
  // bank geometry: eight groups of eight pins, one of them input only
  localparam int NUM_GROUPS = 8;
  localparam int GROUP_W = 8;
  localparam int NUM_PINS = NUM_GROUPS * GROUP_W;
  localparam int PU_BLOCK = 4;
  localparam int PU_PER_GROUP = GROUP_W / PU_BLOCK;
  localparam int PU_BITS = NUM_GROUPS * PU_PER_GROUP;
  localparam int IN_ONLY_GROUP = 6;
  localparam int IN_ONLY_BIT = 5;
  localparam int IN_ONLY_PIN = IN_ONLY_GROUP * GROUP_W + IN_ONLY_BIT;
  localparam int LED_GROUP = 2;
  localparam int TIMER_OUTS = 5;
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [2:0] RGN_DATA = 3'h0;
  localparam logic [2:0] RGN_DIR = 3'h1;
  localparam int RGN_LSB = 5;
  localparam int GRP_LSB = 2;
  localparam logic [7:0] OFS_PULLUP = 8'h40;
  localparam logic [7:0] OFS_LED = 8'h44;
  localparam logic [7:0] OFS_TIMER = 8'h48;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PU_BITS-1:0] RST_PULLUP = 16'h0000;
  localparam logic [TIMER_OUTS-1:0] RST_TIMER = 5'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // pins of group 6 that have no driver; bit 5 is sense only
  localparam logic [7:0] IN_ONLY_MASK6 = 8'h20;
endpackage : gpio_pkg

//--- rtl/group_if.sv
/*
  control and sense signals between the register file and one pin group.
  assumes both ends share the bank clock.
*/
interface group_if;
  logic [7:0] dir;    // 1 = output
  logic [7:0] latch;  // output latch
  logic [1:0] pu_en;  // pull-up enable per block of four
  logic [7:0] p_oe;   // peripheral claims the pin as output
  logic [7:0] p_do;   // peripheral output level
  logic [7:0] sense;  // synchronised pin level
  modport ctl (output dir, latch, pu_en, p_oe, p_do, input sense);
  modport grp (input dir, latch, pu_en, p_oe, p_do, output sense);
endinterface : group_if

//--- rtl/pin_group.sv
/*
  one group of eight pins: input synchroniser and registered pad controls.
  assumes pins are asynchronous to the clock.
*/
module pin_group
  import gpio_pkg::*;
#(
  parameter logic [7:0] IN_ONLY = 8'h00  // pins with no driver and no pull-up
) (
  input wire logic clk_i,
  input wire logic rst_i,
  group_if.grp g,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] oe_o,
  output logic [7:0] pu_o
);
  logic [7:0] meta_r;   // first stage, read only by sense
  logic [7:0] drive;    // pin actually driven
  logic [7:0] pu_bits;  // block enables spread to pins

  // two-stage synchroniser on the pad inputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_BYTE;
      g.sense <= RST_BYTE;
    end else begin
      meta_r <= pin_i;
      g.sense <= meta_r;
    end
  end

  assign drive = (g.dir | g.p_oe) & ~IN_ONLY;
  assign pu_bits = {{PU_BLOCK{g.pu_en[1]}}, {PU_BLOCK{g.pu_en[0]}}};

  // pad controls registered so the pads see no decode glitches
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_o <= RST_BYTE;
      oe_o <= RST_BYTE;
      pu_o <= RST_BYTE;
    end else begin
      pin_o <= ((g.p_oe & g.p_do) | (~g.p_oe & g.latch)) & ~IN_ONLY;
      oe_o <= drive;
      pu_o <= pu_bits & ~drive & ~IN_ONLY;
    end
  end
endmodule : pin_group

//--- bench/pin_devices.sv
/*
  external devices on the port pins: works out each pad level.
  assumes the bench sets which pads a device drives or ties, and to what.
*/
module pin_devices (
  input wire logic clk_i,
  input wire logic [63:0] pin_i,  // bank output level
  input wire logic [63:0] oe_i,  // bank drives the pad
  input wire logic [63:0] pu_i,  // bank pull-up on
  input wire logic [63:0] ext_en_i,  // a device drives or ties the pad
  input wire logic [63:0] ext_val_i,  // level of that device
  output logic [63:0] level_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // an open pad wanders so a stale level can never pass for a read
  logic [63:0] float_r = 64'h5a5a_5a5a_5a5a_5a5a;
  // floating pads change every cycle
  always_ff @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (oe_i[i]) begin
        level_o[i] = pin_i[i];  // bank driver wins
      end else if (ext_en_i[i]) begin
        level_o[i] = ext_val_i[i];  // device or resistor tie
      end else if (pu_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = float_r[i];
      end
    end
  end
endmodule : pin_devices

//--- bench/programmable_io_ports_bench.sv
/*
  self-checking bench for the port bank: register rows, pins, override.
  assumes the pin_devices model closes every pad loop.
*/
module programmable_io_ports_bench;
  import gpio_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] exp; logic err;} row_type;
  // write value, expected read-back, expected error
  localparam row_type ROWS [8] = '{
    '{8'h20, 32'hffff_ffff, 32'h0000_00ff, 1'b0}, '{8'h38, 32'h0000_00ff, 32'h0000_00df, 1'b0},
    '{8'h3c, 32'h0000_005a, 32'h0000_005a, 1'b0}, '{8'h40, 32'hffff_ffff, 32'h0000_ffff, 1'b0},
    '{8'h44, 32'h0000_01ff, 32'h0000_00ff, 1'b0}, '{8'h48, 32'h0000_00ff, 32'h0000_001f, 1'b0},
    '{8'h4c, 32'h0000_00ff, 32'h0000_0000, 1'b1}, '{8'hfc, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [63:0] pin_lvl, pin_out, pin_oe, pin_pu, per_di;
  logic [63:0] per_oe = 64'h0;  // peripheral claims
  logic [63:0] per_do = 64'h0;
  logic [63:0] ext_en = 64'h0;  // external device enables
  logic [63:0] ext_val = 64'h0;
  logic [7:0] led;
  logic [4:0] tmr;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int n_checks = 0;
  programmable_io_ports DUT (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .PIN_I(pin_lvl), .PIN_O(pin_out), .PIN_OE_O(pin_oe), .PIN_PULLUP_O(pin_pu), .PERIPH_OE_I(per_oe),
    .PERIPH_DO_I(per_do), .PERIPH_DI_O(per_di), .LED_SINK_O(led), .TIMER_DRIVE_O(tmr));
  pin_devices devs (.clk_i(clk), .pin_i(pin_out), .oe_i(pin_oe), .pu_i(pin_pu), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(pin_lvl));
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end
  // one comparison, four-state exact
  task check(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one apb transfer; request held until the rising edge that samples pready high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;  // no answer counts as a mismatch
    // answer taken at the very edge that samples pready high
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // let registered pad controls and the synchroniser settle
  task settle();
    repeat (4) @(posedge clk);
    #10;
  endtask : settle
  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // watchdog: whole run needs well under 5000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #10;
    check("oe after reset", 64'h0, pin_oe);
    check("pu after reset", 64'h0, pin_pu);
    check("drive after reset", 13'h0, {led, tmr});
    apb(1'b0, OFS_PULLUP, 32'h0);
    check("pullup reg reset", 32'h0, rd);
    $display("test reset done");
    // register rows: write, read back, error flag on both
    foreach (ROWS[i]) begin
      apb(1'b1, ROWS[i].a, ROWS[i].wd);
      check("write err", ROWS[i].err, er);
      apb(1'b0, ROWS[i].a, 32'h0);
      check("read data", ROWS[i].exp, rd);
      check("read err", ROWS[i].err, er);
    end
    settle();
    check("led drive", 8'hff, led);
    check("timer drive", 5'h1f, tmr);
    check("oe g7", 8'h5a, pin_oe[63:56]);
    check("pu g7", 8'ha5, pin_pu[63:56]);
    check("oe pu g6", 16'h0, {pin_oe[53], pin_pu[55:48], 7'h0});
    check("pu g1", 8'hff, pin_pu[15:8]);
    $display("test rows done");
    // latch out and read the sensed pads, group 1 driven from outside
    ext_en <= 64'h0020_0000_0000_ff00;
    ext_val <= 64'h0020_0000_0000_3c00;
    apb(1'b1, 8'h00, 32'h0000_00a5);
    settle();
    check("pin out g0", 8'ha5, pin_out[7:0]);
    apb(1'b0, 8'h00, 32'h0);
    check("sense g0", 32'h0000_00a5, rd);
    apb(1'b0, 8'h04, 32'h0);
    check("sense g1", 32'h0000_003c, rd);
    check("periph in g1", 8'h3c, per_di[15:8]);
    apb(1'b0, 8'h18, 32'h0);
    check("sense in only", 32'h0000_0020, rd);
    // one pull-up bit covers exactly one block of four
    apb(1'b1, OFS_PULLUP, 32'h0000_0004);
    settle();
    check("pu block", 8'h0f, pin_pu[15:8]);
    $display("test pins done");
    // peripheral drives an input pin and the input-only pin
    per_oe <= 64'h0020_0000_0000_0200;
    per_do <= 64'h0020_0000_0000_0200;
    settle();
    check("override oe", 2'b01, {pin_oe[53], pin_oe[9]});
    check("override out", 1'b1, pin_out[9]);
    check("pu off driven", 8'h0d, pin_pu[15:8]);
    $display("test override done");
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #10;
    check("oe pu after reset", 128'h0, {pin_oe & ~per_oe, pin_pu});
    check("drive after reset", 13'h0, {led, tmr});
    $display("test reset again done");
    stop_test();
  end
endmodule : programmable_io_ports_bench
